// >>> src/icu_pkg.sv
package icu_pkg;

	// register byte offsets on the APB bus
	localparam logic [7:0] CTRL0_OFF = 8'h00;
	localparam logic [7:0] CAPSEL0_OFF = 8'h04;
	localparam logic [7:0] VALLO0_OFF = 8'h08;
	localparam logic [7:0] VALHI0_OFF = 8'h0c;
	localparam logic [7:0] CTRL1_OFF = 8'h10;
	localparam logic [7:0] CAPSEL1_OFF = 8'h14;
	localparam logic [7:0] VALLO1_OFF = 8'h18;
	localparam logic [7:0] VALHI1_OFF = 8'h1c;
	localparam logic [7:0] TMRSEL_OFF = 8'h20;
	localparam logic [7:0] FLAG_OFF = 8'h24;

	// control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OD_BIT = 6;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CAPSEL_RST = 8'h00;
	localparam logic [7:0] TMRSEL_RST = 8'h00;
	localparam logic [15:0] VAL_RST = 16'h0000;

	typedef enum logic [3:0] {
		ICU_MODE_OFF = 4'b0000,
		ICU_MODE_CMP = 4'b0001,
		ICU_MODE_BOTH = 4'b0011,
		ICU_MODE_FALL = 4'b0100,
		ICU_MODE_RISE = 4'b0101,
		ICU_MODE_RISE4 = 4'b0110,
		ICU_MODE_RISE16 = 4'b0111,
		ICU_MODE_PWM = 4'b1100
	} icu_mode_e;

	typedef enum logic [3:0] {
		ICU_SRC_PIN = 4'b0000,
		ICU_SRC_CMP1 = 4'b0001,
		ICU_SRC_CMP2 = 4'b0010,
		ICU_SRC_IOC = 4'b0011
	} icu_src_e;

	localparam logic [3:0] PRESCALE_4 = 4'h3;
	localparam logic [3:0] PRESCALE_16 = 4'hf;

endpackage

// >>> src/icu_edge.sv
`timescale 1ns/1ps
module icu_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sig_in,
	output logic rise,
	output logic fall
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync1_ff <= sig_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;
endmodule

// >>> src/icu_top.sv
`timescale 1ns/1ps
// Contract
// [R1] each capture event copies the assigned 16-bit timer into the value register
// [R2] mode picks falling, rising, every 4th, every 16th rising, or both edges
// [R3] capture sets the event flag; only software clears it
// [R4] a new capture overwrites the stored value even if unread
// [R5] value is read as separate low and high bytes, not snapshotted
// [R6] software should disable the module or read twice for consistency
// [R7] 4-bit source field selects pin, comparators, pin-change, or logic cells 1-8
// [R8] a port write on a pin driven as output can cause a capture
// [R9] capture/compare use odd timers 1/3/5, pwm uses even timers 2/4/6
// [R10] each module has its own timer field in a shared selection register
// [R11] after reset both modules use timer 1 and timer 2
// [R12] modules may share one timer when in the same mode group
// [R13] software must run the capture timer synchronously
// [R14] in compare or pwm mode the pin driver may be open-drain
// [R15] software should make the capture pin an input before capturing
// [R16] each module has control, input select and low/high value registers
// [R17] edge prescaler clears on reset, module off, or non-capture mode only
// [R18] a mode change may raise a spurious flag; software clears it
// [R19] the selected input is synchronised and edge-detected for one strobe per edge
module icu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] capture_pin_route,
	input wire logic [1:0] pin_direction_bit,
	input wire logic [1:0] port_latch,
	input wire logic [1:0] comparator_output,
	input wire logic pin_change_event,
	input wire logic [7:0] logic_cell_output,
	input wire logic [15:0] odd_timer_one,
	input wire logic [15:0] odd_timer_three,
	input wire logic [15:0] odd_timer_five,
	input wire logic [1:0] out_level,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe,
	output logic [1:0] capture_event_flag,
	output logic [1:0] odd_timer_sel,
	output logic [1:0] even_timer_sel,
	output logic [3:0] even_timer_sel_raw
);
	logic [7:0] ctrl_ff [2];
	logic [7:0] capsel_ff [2];
	logic [15:0] value_ff [2];
	logic [3:0] presc_ff [2];
	logic [7:0] tmrsel_ff;
	logic [1:0] flag_ff;
	logic [31:0] prdata_ff;

	logic wr_en;
	logic rd_en;
	logic hit;
	logic [1:0] flag_clr;
	logic [1:0] cap_strobe;
	logic [1:0] pin_level;
	logic [1:0] src_level;
	logic [1:0] rise_w;
	logic [1:0] fall_w;
	logic [1:0] is_capture;
	logic [1:0] is_output;
	logic [1:0] presc_keep;
	logic [15:0] timer_pick [2];
	logic [3:0] nxt_presc [2];
	logic sel_ctrl0;
	logic sel_ctrl1;
	logic sel_capsel0;
	logic sel_capsel1;
	logic sel_vallo0;
	logic sel_valhi0;
	logic sel_vallo1;
	logic sel_valhi1;
	logic sel_tmrsel;
	logic sel_flag;
	logic [7:0] rd_byte;

	// timer select: 2 bits per module, 0 -> timer1 (cap/cmp) or timer2 (pwm)
	function automatic logic [15:0] pick_timer(input logic [1:0] sel, input logic [15:0] t1,
		input logic [15:0] t3, input logic [15:0] t5);
		logic [15:0] r;
		r = t1;
		if (sel == 2'd1) begin
			r = t3;
		end else if (sel == 2'd2) begin
			r = t5;
		end
		return r;
	endfunction

	function automatic logic mode_is_capture(input logic [7:0] ctrl);
		logic [3:0] m;
		m = ctrl[icu_pkg::CTRL_MODE_LSB +: icu_pkg::CTRL_MODE_W];
		return ctrl[icu_pkg::CTRL_EN_BIT] && (m == icu_pkg::ICU_MODE_BOTH ||
			m == icu_pkg::ICU_MODE_FALL || m == icu_pkg::ICU_MODE_RISE ||
			m == icu_pkg::ICU_MODE_RISE4 || m == icu_pkg::ICU_MODE_RISE16);
	endfunction

	// full 8-bit match, so unaligned or unmapped addresses select nothing
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;

	// one select per register, shared by the write enables and the read mux
	assign sel_ctrl0 = addr_is(paddr, icu_pkg::CTRL0_OFF);
	assign sel_ctrl1 = addr_is(paddr, icu_pkg::CTRL1_OFF);
	assign sel_capsel0 = addr_is(paddr, icu_pkg::CAPSEL0_OFF);
	assign sel_capsel1 = addr_is(paddr, icu_pkg::CAPSEL1_OFF);
	assign sel_vallo0 = addr_is(paddr, icu_pkg::VALLO0_OFF);
	assign sel_valhi0 = addr_is(paddr, icu_pkg::VALHI0_OFF);
	assign sel_vallo1 = addr_is(paddr, icu_pkg::VALLO1_OFF);
	assign sel_valhi1 = addr_is(paddr, icu_pkg::VALHI1_OFF);
	assign sel_tmrsel = addr_is(paddr, icu_pkg::TMRSEL_OFF);
	assign sel_flag = addr_is(paddr, icu_pkg::FLAG_OFF);
	assign hit = sel_ctrl0 | sel_ctrl1 | sel_capsel0 | sel_capsel1 | sel_vallo0 | sel_valhi0 |
		sel_vallo1 | sel_valhi1 | sel_tmrsel | sel_flag;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_ff;
	// write one to clear
	assign flag_clr = (wr_en && sel_flag) ? pwdata[1:0] : 2'b00; // R3

	assign odd_timer_sel = {tmrsel_ff[2] | tmrsel_ff[3], tmrsel_ff[0] | tmrsel_ff[1]}; // R10
	assign even_timer_sel_raw = tmrsel_ff[3:0]; // R9
	assign even_timer_sel = {ctrl_ff[1][3:2] == 2'b11, ctrl_ff[0][3:2] == 2'b11};
	assign capture_event_flag = flag_ff;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_mod
			assign is_capture[g] = mode_is_capture(ctrl_ff[g]);
			assign is_output[g] = ctrl_ff[g][icu_pkg::CTRL_EN_BIT] & ~is_capture[g];
			// pin level as seen from the pad: port latch when driven as output
			assign pin_level[g] = pin_direction_bit[g] ? capture_pin_route[g] : port_latch[g]; // R8
			always_comb begin
				src_level[g] = 1'b0;
				case (capsel_ff[g][3:0]) // R7
					icu_pkg::ICU_SRC_PIN: src_level[g] = pin_level[g];
					icu_pkg::ICU_SRC_CMP1: src_level[g] = comparator_output[0];
					icu_pkg::ICU_SRC_CMP2: src_level[g] = comparator_output[1];
					icu_pkg::ICU_SRC_IOC: src_level[g] = pin_change_event;
					default: src_level[g] = capsel_ff[g][3] ? logic_cell_output[capsel_ff[g][2:0]] : 1'b0;
				endcase
			end
			icu_edge u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.sig_in(src_level[g]),
				.rise(rise_w[g]),
				.fall(fall_w[g])
			); // R19
			assign timer_pick[g] = pick_timer(tmrsel_ff[2*g +: 2], odd_timer_one,
				odd_timer_three, odd_timer_five); // R9 R12
			assign presc_keep[g] = is_capture[g]; // R17
			always_comb begin
				nxt_presc[g] = presc_ff[g];
				cap_strobe[g] = 1'b0;
				case (ctrl_ff[g][3:0]) // R2
					icu_pkg::ICU_MODE_FALL: cap_strobe[g] = fall_w[g];
					icu_pkg::ICU_MODE_RISE: cap_strobe[g] = rise_w[g];
					icu_pkg::ICU_MODE_BOTH: cap_strobe[g] = rise_w[g] | fall_w[g];
					icu_pkg::ICU_MODE_RISE4: begin
						if (rise_w[g]) begin
							cap_strobe[g] = (presc_ff[g][1:0] == icu_pkg::PRESCALE_4[1:0]);
							nxt_presc[g] = presc_ff[g] + 4'd1;
						end
					end
					icu_pkg::ICU_MODE_RISE16: begin
						if (rise_w[g]) begin
							cap_strobe[g] = (presc_ff[g] == icu_pkg::PRESCALE_16);
							nxt_presc[g] = presc_ff[g] + 4'd1;
						end
					end
					default: cap_strobe[g] = 1'b0;
				endcase
				if (!presc_keep[g]) begin
					cap_strobe[g] = 1'b0;
					nxt_presc[g] = 4'd0; // R17
				end
			end
			// open-drain: drive only low when selected
			assign pin_oe[g] = is_output[g] &
				(~ctrl_ff[g][icu_pkg::CTRL_OD_BIT] | ~out_level[g]); // R14
			assign pin_out[g] = ctrl_ff[g][icu_pkg::CTRL_OD_BIT] ? 1'b0 : out_level[g];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					presc_ff[g] <= 4'd0;
					value_ff[g] <= icu_pkg::VAL_RST;
				end else begin
					presc_ff[g] <= nxt_presc[g];
					if (cap_strobe[g]) begin
						value_ff[g] <= timer_pick[g]; // R1 R4
					end
				end
			end
		end
	endgenerate

	// register writes, one short process per register; value bytes are read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff[0] <= icu_pkg::CTRL_RST;
		end else if (wr_en && sel_ctrl0) begin
			ctrl_ff[0] <= pwdata[7:0]; // R16
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff[1] <= icu_pkg::CTRL_RST;
		end else if (wr_en && sel_ctrl1) begin
			ctrl_ff[1] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capsel_ff[0] <= icu_pkg::CAPSEL_RST;
		end else if (wr_en && sel_capsel0) begin
			capsel_ff[0] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capsel_ff[1] <= icu_pkg::CAPSEL_RST;
		end else if (wr_en && sel_capsel1) begin
			capsel_ff[1] <= pwdata[7:0];
		end
	end

	// both modules' timer fields live in one shared register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmrsel_ff <= icu_pkg::TMRSEL_RST; // R11
		end else if (wr_en && sel_tmrsel) begin
			tmrsel_ff <= pwdata[7:0]; // R10
		end
	end

	// set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_ff <= 2'b00;
		end else begin
			flag_ff <= (flag_ff & ~flag_clr) | cap_strobe; // R3 R18
		end
	end

	// read byte picked from the decoded address; value bytes are read live, no snapshot
	always_comb begin
		rd_byte = 8'h00;
		if (sel_ctrl0) begin
			rd_byte = ctrl_ff[0];
		end else if (sel_ctrl1) begin
			rd_byte = ctrl_ff[1];
		end else if (sel_capsel0) begin
			rd_byte = capsel_ff[0];
		end else if (sel_capsel1) begin
			rd_byte = capsel_ff[1];
		end else if (sel_vallo0) begin
			rd_byte = value_ff[0][7:0]; // R5
		end else if (sel_valhi0) begin
			rd_byte = value_ff[0][15:8]; // R5
		end else if (sel_vallo1) begin
			rd_byte = value_ff[1][7:0];
		end else if (sel_valhi1) begin
			rd_byte = value_ff[1][15:8];
		end else if (sel_tmrsel) begin
			rd_byte = tmrsel_ff;
		end else if (sel_flag) begin
			rd_byte = {6'h00, flag_ff};
		end
	end

	// read data latched in the setup phase and held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata_ff <= {24'h00_0000, rd_byte};
		end
	end
endmodule

// >>> tb/icu_sva.sv
`timescale 1ns/1ps
module icu_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] capture_event_flag,
	input wire logic [1:0] odd_timer_sel,
	input wire logic [1:0] even_timer_sel
);
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic [1:0] clr = {2{wr && paddr == icu_pkg::FLAG_OFF}} & pwdata[1:0];
	wire logic tsw = wr && paddr == icu_pkg::TMRSEL_OFF;
	wire logic csw = wr && (paddr == icu_pkg::CTRL0_OFF || paddr == icu_pkg::CTRL1_OFF);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (pready) else $error("ready low");
	err_phase_a: assert property (pslverr |-> acc) else $error("stray error");
	err_map_a: assert property (acc && paddr > 8'h24 |-> pslverr) else $error("no error");
	ok_map_a: assert property (
		acc && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr) else $error("false error");
	flag_keep_a: assert property (
		capture_event_flag[0] && !clr[0] |=> capture_event_flag[0]) else $error("flag lost");
	flag_fall_a: assert property (
		$fell(capture_event_flag[1]) |-> $past(clr[1])) else $error("flag dropped");
	tsel_chg_a: assert property (
		$changed(odd_timer_sel) |-> $past(tsw)) else $error("odd select moved");
	esel_chg_a: assert property (
		$changed(even_timer_sel) |-> $past(csw)) else $error("even select moved");
	cover property ($rose(capture_event_flag[0]));
	cover property ($rose(even_timer_sel[0]));
	cover property (pslverr);
	cover property (tsw);
endmodule

// >>> tb/icu_src_model.sv
`timescale 1ns/1ps
module icu_src_model (
	input wire logic pclk,
	output logic [1:0] capture_pin_route,
	output logic [1:0] comparator_output,
	output logic pin_change_event,
	output logic [7:0] logic_cell_output,
	output logic [15:0] odd_timer_one,
	output logic [15:0] odd_timer_three,
	output logic [15:0] odd_timer_five
);
	initial {capture_pin_route, comparator_output, pin_change_event, logic_cell_output,
		odd_timer_one, odd_timer_three, odd_timer_five} = '0;
	// timers only move on pclk edges, as a synchronised timer would
	task automatic tm(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		@(posedge pclk);
		odd_timer_one <= a;
		odd_timer_three <= b;
		odd_timer_five <= c;
	endtask
	task automatic set(input int m, input int c, input logic l);
		@(posedge pclk);
		case (c)
			0: capture_pin_route[m] <= l;
			1: comparator_output[0] <= l;
			2: comparator_output[1] <= l;
			3: pin_change_event <= l;
			default: logic_cell_output[c - 8] <= l;
		endcase
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pin_change_event;
	logic [7:0] paddr, logic_cell_output;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] capture_pin_route, pin_direction_bit, port_latch, comparator_output;
	logic [1:0] capture_event_flag;
	logic [15:0] odd_timer_one, odd_timer_three, odd_timer_five;
	logic [1:0] out_level, pin_out, pin_oe, odd_timer_sel, even_timer_sel;
	logic [3:0] even_timer_sel_raw;
	int mismatches, comparisons, cyc;
	icu_top dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.capture_pin_route(capture_pin_route),
		.pin_direction_bit(pin_direction_bit),
		.port_latch(port_latch),
		.comparator_output(comparator_output),
		.pin_change_event(pin_change_event),
		.logic_cell_output(logic_cell_output),
		.odd_timer_one(odd_timer_one),
		.odd_timer_three(odd_timer_three),
		.odd_timer_five(odd_timer_five),
		.out_level(out_level),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.capture_event_flag(capture_event_flag),
		.odd_timer_sel(odd_timer_sel),
		.even_timer_sel(even_timer_sel),
		.even_timer_sel_raw(even_timer_sel_raw)
	);
	icu_src_model src (
		.pclk(pclk),
		.capture_pin_route(capture_pin_route),
		.comparator_output(comparator_output),
		.pin_change_event(pin_change_event),
		.logic_cell_output(logic_cell_output),
		.odd_timer_one(odd_timer_one),
		.odd_timer_three(odd_timer_three),
		.odd_timer_five(odd_timer_five)
	);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ev(input int m, input int c, input logic l);
		src.set(m, c, l);
		repeat (5) @(posedge pclk);
	endtask
	task automatic clr();
		acc(1'b1, icu_pkg::FLAG_OFF, 32'h0000_0003);
	endtask
	task automatic cf(input logic [1:0] e);
		chk(32'(capture_event_flag), 32'(e));
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		port_latch = 2'b00;
		out_level = 2'b00;
		pin_direction_bit = 2'b11;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, icu_pkg::TMRSEL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		acc(1'b0, 8'h28, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		src.tm(16'h1234, 16'h5678, 16'h9abc);
		for (int i = 3; i < 6; i++) begin
			acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_0080 + 32'(i));
			ev(0, 0, 1'b0);
			clr();
			ev(0, 0, 1'b1);
			cf({1'b0, i != 4});
			clr();
			ev(0, 0, 1'b0);
			cf({1'b0, i != 5});
		end
		acc(1'b0, icu_pkg::VALHI0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0012);
		src.tm(16'hbeef, 16'h5678, 16'h9abc);
		ev(0, 0, 1'b1);
		acc(1'b0, icu_pkg::VALLO0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00ef);
		acc(1'b0, icu_pkg::VALHI0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00be);
		src.tm(16'hcafe, 16'h5678, 16'h9abc);
		ev(0, 0, 1'b0);
		ev(0, 0, 1'b1);
		acc(1'b0, icu_pkg::VALHI0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00ca);
		acc(1'b0, icu_pkg::VALLO0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00fe);
		acc(1'b0, icu_pkg::VALHI0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_00ca);
		for (int n = 4; n <= 16; n += 12) begin
			acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_0000);
			acc(1'b1, icu_pkg::CTRL0_OFF, n == 4 ? 32'h0000_0086 : 32'h0000_0087);
			ev(0, 0, 1'b0);
			clr();
			for (int k = 1; k < n + 3; k++) begin
				ev(0, 0, 1'b1);
				cf({1'b0, k == n});
				ev(0, 0, 1'b0);
				clr();
			end
		end
		acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_0085);
		for (int c = 1; c < 16; c++) begin
			if (c < 4 || c > 7) begin
				acc(1'b1, icu_pkg::CAPSEL0_OFF, 32'(c));
				ev(0, c, 1'b0);
				clr();
				ev(0, c, 1'b1);
				cf(2'b01);
			end
		end
		acc(1'b1, icu_pkg::TMRSEL_OFF, 32'h0000_0009);
		acc(1'b1, icu_pkg::CTRL1_OFF, 32'h0000_0085);
		acc(1'b1, icu_pkg::CAPSEL0_OFF, 32'h0000_0000);
		ev(1, 0, 1'b0);
		clr();
		ev(0, 0, 1'b1);
		ev(1, 0, 1'b1);
		cf(2'b11);
		acc(1'b0, icu_pkg::VALLO0_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0078);
		acc(1'b0, icu_pkg::VALHI1_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_009a);
		chk(32'(odd_timer_sel), 32'h0000_0003);
		chk(32'(even_timer_sel_raw), 32'h0000_0009);
		acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_008c);
		@(posedge pclk);
		chk(32'(even_timer_sel), 32'h0000_0001);
		out_level <= 2'b01;
		acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_0081);
		@(posedge pclk);
		chk(32'({pin_oe[0], pin_out[0]}), 32'h0000_0003);
		acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_00c1);
		@(posedge pclk);
		chk(32'(pin_oe[0]), 32'h0000_0000);
		out_level <= 2'b00;
		@(posedge pclk);
		chk(32'({pin_oe[0], pin_out[0]}), 32'h0000_0002);
		acc(1'b1, icu_pkg::CTRL0_OFF, 32'h0000_0085);
		pin_direction_bit <= 2'b10;
		repeat (5) @(posedge pclk);
		clr();
		port_latch <= 2'b01;
		repeat (5) @(posedge pclk);
		cf(2'b01);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, icu_pkg::TMRSEL_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(32'(odd_timer_sel), 32'h0000_0000);
		test_done();
	end
endmodule
bind icu_top icu_sva chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.pslverr(pslverr),
	.capture_event_flag(capture_event_flag),
	.odd_timer_sel(odd_timer_sel),
	.even_timer_sel(even_timer_sel)
);
